// ### rtl/clk_sel_pkg.sv
// Shared constants and types for the audio clock source selector
package clk_sel_pkg;

    localparam int NUM_INPUTS   = 5;
    localparam int SRC_W        = 3;
    localparam int RATE_W       = 4;
    localparam int FRAME_DIV_W  = 8;

    // Clock source codes
    localparam logic [SRC_W-1:0] SRC_INTERNAL = 3'h0;
    localparam logic [SRC_W-1:0] SRC_WORD     = 3'h1;
    localparam logic [SRC_W-1:0] SRC_MADI1    = 3'h2;
    localparam logic [SRC_W-1:0] SRC_MADI2    = 3'h3;
    localparam logic [SRC_W-1:0] SRC_MADI3    = 3'h4;
    localparam logic [SRC_W-1:0] SRC_AES      = 3'h5;

    // Input index within the vectors
    localparam int IDX_WORD  = 0;
    localparam int IDX_MADI1 = 1;
    localparam int IDX_MADI2 = 2;
    localparam int IDX_MADI3 = 3;
    localparam int IDX_AES   = 4;

    // Rate codes; zero means nothing recognised
    localparam logic [RATE_W-1:0] RATE_NONE = 4'h0;

    // Clock state per input
    localparam logic [1:0] STATE_NO_LOCK = 2'h0;
    localparam logic [1:0] STATE_LOCK    = 2'h1;
    localparam logic [1:0] STATE_SYNC    = 2'h2;

    // Frames a state change must persist before it is accepted
    localparam int DEBOUNCE_FRAMES = 4;

    // One input's raw observation on the link side
    typedef struct packed {
        logic              locked;
        logic              synced;
        logic              madi_56ch;
        logic [RATE_W-1:0] rate;
    } link_obs_s;

    // Per-input status reported to the host side
    typedef struct packed {
        logic [1:0]        state;
        logic [RATE_W-1:0] rate;
        logic              madi_56ch;
    } input_status_s;

    typedef enum logic {
        MODE_AUTO,
        MODE_FORCE_INTERNAL
    } clock_mode_e;

endpackage : clk_sel_pkg

// ### rtl/input_debounce.sv
// Link-clock debouncer for one input's observation
`timescale 1ns/1ps
`default_nettype none
module input_debounce
    import clk_sel_pkg::*;
#(
    parameter int FRAMES = DEBOUNCE_FRAMES
) (
    input  wire logic      link_clock,
    input  wire logic      link_rst_b,
    input  wire logic      frame_tick,
    input  wire link_obs_s raw,
    output link_obs_s      stable
);
    if (FRAMES < 1 || FRAMES > 255) begin : g_bad_frames
        $error("FRAMES out of range");
    end

    link_obs_s  cand_ff;
    logic [7:0] cnt_ff;
    link_obs_s  stable_ff;

    // A new value must hold for FRAMES frames before it is taken
    always_ff @(posedge link_clock) begin
        if (!link_rst_b) begin
            cand_ff <= '0;
            cnt_ff  <= 8'h00;
        end else if (raw != cand_ff) begin
            cand_ff <= raw;
            cnt_ff  <= 8'h00;
        end else if (frame_tick && cnt_ff != 8'(FRAMES)) begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge link_clock) begin
        if (!link_rst_b) begin
            stable_ff <= '0;
        end else if (cnt_ff == 8'(FRAMES)) begin
            stable_ff <= cand_ff;
        end
    end

    assign stable = stable_ff;

endmodule : input_debounce
`default_nettype wire

// ### rtl/word_sync.sv
// Two-flop level synchroniser for a word of independent levels
`timescale 1ns/1ps
`default_nettype none
module word_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0]      sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : word_sync
`default_nettype wire

// ### rtl/audio_clock_source_select.sv
// Clock reference selection and input state monitoring for digital audio
// Notes on behaviour
// - Automatic mode monitors all inputs continuously
// - Valid input found: run from recovered clock
// - Reference lost: move to next valid input, else internal master
// - Keep preferred input; else current one; else scan others
// - No valid input: master on internal
// - Report no lock, lock or sync
// - Unrecognised rate: not locked, no rate
// - Report rate, lock, sync per input
// - Report rate of current reference
// - Slave: external rate wins over host
// - Flag requested versus detected rate mismatch
// - Forced internal mode disables following
// - Recording starts only with valid input
// - Sources: internal, word, MADI, AES
// - Report MADI 64 or 56 channel format
`timescale 1ns/1ps
`default_nettype none
module audio_clock_source_select
    import clk_sel_pkg::*;
#(
    parameter int N_IN   = NUM_INPUTS,
    parameter int FRAMES = DEBOUNCE_FRAMES
) (
    input  wire logic                clock,
    input  wire logic                rst_b,
    input  wire logic                link_clock,
    input  wire logic                link_rst_b,
    input  wire logic                link_frame_tick,
    input  wire link_obs_s [N_IN-1:0] link_obs,
    input  wire logic                force_internal,
    input  wire logic [SRC_W-1:0]    preferred_source,
    input  wire logic [RATE_W-1:0]   host_rate,
    input  wire logic [RATE_W-1:0]   internal_rate,
    input  wire logic [N_IN-1:0]     record_request,
    output input_status_s [N_IN-1:0] input_status,
    output logic [SRC_W-1:0]         current_source,
    output logic                     clock_master,
    output logic [RATE_W-1:0]        current_rate,
    output logic [RATE_W-1:0]        effective_rate,
    output logic                     rate_mismatch,
    output logic [N_IN-1:0]          record_enable
);
    localparam int OBS_W = $bits(link_obs_s);

    if (N_IN != NUM_INPUTS) begin : g_bad_n_in
        $error("N_IN must match the five audio inputs");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link side: debounce each input on the shared link clock, then cross
    ////////////////////////////////////////////////////////////////////////////

    link_obs_s [N_IN-1:0] link_stable;
    link_obs_s [N_IN-1:0] core_obs;
    logic [N_IN*OBS_W-1:0] link_flat;
    logic [N_IN*OBS_W-1:0] core_flat;

    for (genvar g = 0; g < N_IN; g++) begin : g_deb
        input_debounce #(
            .FRAMES (FRAMES)
        ) u_deb (
            .link_clock (link_clock),
            .link_rst_b (link_rst_b),
            .frame_tick (link_frame_tick),
            .raw        (link_obs[g]),
            .stable     (link_stable[g])
        );
        assign link_flat[g*OBS_W +: OBS_W] = link_stable[g];
        assign core_obs[g] = core_flat[g*OBS_W +: OBS_W];
    end

    // Each field is a slow debounced level; a brief mix of old and new
    // fields is cleaned by the second qualification stage below.
    word_sync #(
        .WIDTH (N_IN*OBS_W)
    ) u_sync (
        .clock    (clock),
        .rst_b    (rst_b),
        .async_in (link_flat),
        .sync_out (core_flat)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-input status
    ////////////////////////////////////////////////////////////////////////////

    link_obs_s [N_IN-1:0] prev_ff;
    link_obs_s [N_IN-1:0] obs_ff;
    logic [N_IN-1:0]      valid;

    // Bits of one crossing word may resolve a cycle apart, so a word is
    // taken only once two samples in a row agree
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= core_obs;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            obs_ff <= '0;
        end else begin
            for (int i = 0; i < N_IN; i++) begin
                if (core_obs[i] == prev_ff[i]) begin
                    obs_ff[i] <= core_obs[i];
                end
            end
        end
    end

    function automatic logic is_valid(input link_obs_s o);
        return o.locked && (o.rate != RATE_NONE);
    endfunction

    function automatic logic [SRC_W-1:0] src_of(input int idx);
        return SRC_W'(idx + 1);
    endfunction

    input_status_s [N_IN-1:0] nxt_status;
    input_status_s [N_IN-1:0] status_ff;

    always_comb begin
        for (int i = 0; i < N_IN; i++) begin
            valid[i] = is_valid(obs_ff[i]);
            nxt_status[i].rate      = valid[i] ? obs_ff[i].rate : RATE_NONE;
            nxt_status[i].madi_56ch = (i >= IDX_MADI1 && i <= IDX_MADI3)
                                      && valid[i] && obs_ff[i].madi_56ch;
            if (!valid[i]) begin
                nxt_status[i].state = STATE_NO_LOCK;
            end else if (obs_ff[i].synced) begin
                nxt_status[i].state = STATE_SYNC;
            end else begin
                nxt_status[i].state = STATE_LOCK;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    assign input_status = status_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Source selection
    ////////////////////////////////////////////////////////////////////////////

    logic [SRC_W-1:0] nxt_source;
    logic [SRC_W-1:0] source_ff;
    logic             pref_ok;
    logic             cur_ok;
    logic             found;
    int               pidx;
    int               cidx;
    int               k;

    always_comb begin
        nxt_source = SRC_INTERNAL;
        found      = 1'b0;
        pidx       = int'(preferred_source) - 1;
        cidx       = int'(source_ff) - 1;
        k          = 0;
        pref_ok    = (pidx >= 0) && (pidx < N_IN) && valid[pidx];
        cur_ok     = (cidx >= 0) && (cidx < N_IN) && valid[cidx];
        if (force_internal) begin
            nxt_source = SRC_INTERNAL;
        end else if (pref_ok) begin
            nxt_source = preferred_source;
        end else if (cur_ok) begin
            nxt_source = source_ff;
        end else begin
            // Scan the others in turn, starting after the preferred one
            for (int j = 1; j <= N_IN; j++) begin
                k = (pidx < 0 ? j - 1 : pidx + j) % N_IN;
                if (!found && valid[k]) begin
                    nxt_source = src_of(k);
                    found      = 1'b1;
                end
            end
            if (!found) begin
                nxt_source = SRC_INTERNAL;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            source_ff <= SRC_INTERNAL;
        end else begin
            source_ff <= nxt_source;
        end
    end

    assign current_source = source_ff;
    assign clock_master   = (source_ff == SRC_INTERNAL);

    ////////////////////////////////////////////////////////////////////////////
    // Rates, mismatch flag and recording gate
    ////////////////////////////////////////////////////////////////////////////

    logic [RATE_W-1:0] cur_rate_ff;
    logic [RATE_W-1:0] eff_rate_ff;
    logic              mismatch_ff;
    logic [N_IN-1:0]   rec_ff;
    logic [RATE_W-1:0] src_rate;

    always_comb begin
        src_rate = RATE_NONE;
        for (int i = 0; i < N_IN; i++) begin
            if (source_ff == src_of(i)) begin
                src_rate = status_ff[i].rate;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cur_rate_ff <= RATE_NONE;
        end else begin
            cur_rate_ff <= src_rate;
        end
    end

    // Slave: the received rate wins; the host's request waits for master
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            eff_rate_ff <= RATE_NONE;
        end else if (clock_master) begin
            // No host request leaves the crystal's own rate standing
            eff_rate_ff <= (host_rate == RATE_NONE) ? internal_rate : host_rate;
        end else begin
            eff_rate_ff <= src_rate;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mismatch_ff <= 1'b0;
        end else begin
            mismatch_ff <= !clock_master && (src_rate != host_rate);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rec_ff <= '0;
        end else begin
            rec_ff <= record_request & valid;
        end
    end

    assign current_rate   = cur_rate_ff;
    assign effective_rate = eff_rate_ff;
    assign rate_mismatch  = mismatch_ff;
    assign record_enable  = rec_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////////

    chk_forced_internal: assert property (@(posedge clock) disable iff (!rst_b)
        force_internal |=> current_source == SRC_INTERNAL)
        else $error("forced internal mode did not select internal clock");

    chk_none_master: assert property (@(posedge clock) disable iff (!rst_b)
        (valid == '0) |=> clock_master)
        else $error("no valid input but not master");

    chk_pref_used: assert property (@(posedge clock) disable iff (!rst_b)
        (!force_internal && pref_ok) |=> current_source == $past(preferred_source))
        else $error("valid preferred input not selected");

    chk_auto_follow: assert property (@(posedge clock) disable iff (!rst_b)
        (!force_internal && valid != '0) |=> !clock_master)
        else $error("valid input present but still on internal clock");

    chk_lost_ref: assert property (@(posedge clock) disable iff (!rst_b)
        (!clock_master && !cur_ok && !pref_ok && valid == '0) |=> clock_master)
        else $error("lost reference did not revert to master");

    chk_nolock_rate: assert property (@(posedge clock) disable iff (!rst_b)
        (status_ff[IDX_WORD].state == STATE_NO_LOCK) |-> status_ff[IDX_WORD].rate == RATE_NONE)
        else $error("unlocked input shows a rate");

    chk_record_gate: assert property (@(posedge clock) disable iff (!rst_b)
        record_enable[IDX_AES] |-> $past(valid[IDX_AES]))
        else $error("recording enabled without valid input");

    chk_mismatch: assert property (@(posedge clock) disable iff (!rst_b)
        (!clock_master && src_rate != host_rate) |=> rate_mismatch)
        else $error("rate mismatch not flagged");

    chk_slave_rate: assert property (@(posedge clock) disable iff (!rst_b)
        (!clock_master) |=> effective_rate == $past(src_rate))
        else $error("host rate overrode external rate in slave mode");

    chk_master_rate: assert property (@(posedge clock) disable iff (!rst_b)
        (clock_master && host_rate != RATE_NONE) |=> effective_rate == $past(host_rate))
        else $error("host rate not applied in master mode");

    chk_default_rate: assert property (@(posedge clock) disable iff (!rst_b)
        (clock_master && host_rate == RATE_NONE) |=> effective_rate == $past(internal_rate))
        else $error("crystal rate not applied without host request");

    chk_internal_no_rate: assert property (@(posedge clock) disable iff (!rst_b)
        clock_master |=> current_rate == RATE_NONE)
        else $error("reference rate shown while on internal clock");

    chk_keep_current: assert property (@(posedge clock) disable iff (!rst_b)
        (!force_internal && !pref_ok && cur_ok) |=> $stable(current_source))
        else $error("still valid reference was dropped");

    chk_master_no_flag: assert property (@(posedge clock) disable iff (!rst_b)
        clock_master |=> !rate_mismatch)
        else $error("rate mismatch flagged in master mode");

    chk_cross_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (obs_ff[IDX_WORD] != $past(obs_ff[IDX_WORD])) |->
        ($past(core_obs[IDX_WORD]) == $past(prev_ff[IDX_WORD])))
        else $error("crossed word taken before two samples agreed");

    chk_madi_format: assert property (@(posedge clock) disable iff (!rst_b)
        !input_status[IDX_WORD].madi_56ch && !input_status[IDX_AES].madi_56ch)
        else $error("channel format shown on a non MADI input");

    chk_valid_rate: assert property (@(posedge clock) disable iff (!rst_b)
        (input_status[IDX_AES].state != STATE_NO_LOCK) |-> input_status[IDX_AES].rate != RATE_NONE)
        else $error("locked input shows no rate");

    chk_record_drop: assert property (@(posedge clock) disable iff (!rst_b)
        !valid[IDX_WORD] |=> !record_enable[IDX_WORD])
        else $error("recording stays enabled on invalid input");

endmodule : audio_clock_source_select
`default_nettype wire

// ### bench/audio_source_model.sv
// Behavioural model of the external digital audio sources on the link side
`timescale 1ns/1ps
`default_nettype none
module audio_source_model
    import clk_sel_pkg::*;
(
    input  wire logic                       link_clock,
    input  wire logic                       rst_b,
    input  wire link_obs_s [NUM_INPUTS-1:0] want,
    output logic                            link_rst_b,
    output logic                            link_frame_tick,
    output link_obs_s [NUM_INPUTS-1:0]      link_obs
);
    logic [1:0] rst_pipe_ff;
    logic [1:0] frame_cnt_ff;

    // Re-timed so the link side leaves reset on its own clock edge
    always_ff @(posedge link_clock) begin
        rst_pipe_ff <= {rst_pipe_ff[0], rst_b};
    end
    assign link_rst_b = rst_pipe_ff[1];

    // Audio links run free: one frame every four link cycles
    always_ff @(posedge link_clock) begin
        frame_cnt_ff    <= link_rst_b ? frame_cnt_ff + 2'h1 : 2'h0;
        link_frame_tick <= link_rst_b && (frame_cnt_ff == 2'h3);
    end

    // Every source is a slave of one master; the bench decides what each carries
    always_ff @(posedge link_clock) begin
        link_obs <= want;
    end
endmodule // audio_source_model
`default_nettype wire

// ### bench/audio_clock_source_select_tb.sv
// Self-checking testbench for the audio clock source selector
`timescale 1ns/1ps
`default_nettype none
module audio_clock_source_select_tb
    import clk_sel_pkg::*;
();
    localparam int FR = 2;
    logic                           clock;
    logic                           rst_b;
    logic                           link_clock;
    logic                           link_rst_b;
    logic                           link_frame_tick;
    logic                           force_internal;
    logic [SRC_W-1:0]               preferred_source;
    logic [RATE_W-1:0]              host_rate;
    logic [RATE_W-1:0]              internal_rate;
    logic [NUM_INPUTS-1:0]          record_request;
    link_obs_s [NUM_INPUTS-1:0]     want;
    link_obs_s [NUM_INPUTS-1:0]     obs;
    link_obs_s [NUM_INPUTS-1:0]     link_obs;
    input_status_s [NUM_INPUTS-1:0] input_status;
    logic [SRC_W-1:0]               current_source;
    logic                           clock_master;
    logic [RATE_W-1:0]              current_rate;
    logic [RATE_W-1:0]              effective_rate;
    logic                           rate_mismatch;
    logic [NUM_INPUTS-1:0]          record_enable;
    int                             n_errors;
    int                             checks_done;

    audio_clock_source_select #(.N_IN(NUM_INPUTS), .FRAMES(FR)) DUT (
        .clock(clock), .rst_b(rst_b), .link_clock(link_clock), .link_rst_b(link_rst_b),
        .link_frame_tick(link_frame_tick), .link_obs(link_obs),
        .force_internal(force_internal), .preferred_source(preferred_source),
        .host_rate(host_rate), .internal_rate(internal_rate),
        .record_request(record_request), .input_status(input_status),
        .current_source(current_source), .clock_master(clock_master),
        .current_rate(current_rate), .effective_rate(effective_rate),
        .rate_mismatch(rate_mismatch), .record_enable(record_enable)
    );

    audio_source_model sources (
        .link_clock(link_clock), .rst_b(rst_b), .want(want), .link_rst_b(link_rst_b),
        .link_frame_tick(link_frame_tick), .link_obs(link_obs)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Link clock is unrelated in phase to the core clock
    initial begin
        link_clock = 1'b0;
        #13;
        forever #80 link_clock = ~link_clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Counts: %0d checks, %0d mismatches", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic drive(input logic [2:0] pref, input logic frc, input logic [3:0] hr,
                         input logic [4:0] rec);
        @(posedge clock);
        want             <= obs;
        preferred_source <= pref;
        force_internal   <= frc;
        host_rate        <= hr;
        record_request   <= rec;
    endtask

    // Covers debounce, two-flop crossing and status registers with margin
    task automatic settle();
        repeat (120) @(posedge clock);
        @(negedge clock);
    endtask

    // Master: host rate stands, or the crystal's if none asked; slave: reference wins
    task automatic core(input logic [2:0] src, input logic [3:0] rate);
        logic       ms;
        logic [3:0] mr;
        ms = (src == SRC_INTERNAL);
        mr = (host_rate == RATE_NONE) ? internal_rate : host_rate;
        check({3'h0, current_source, clock_master, current_rate, effective_rate, rate_mismatch},
              {3'h0, src, ms, rate, ms ? mr : rate, !ms && (rate != host_rate)},
              "source and rates");
    endtask

    task automatic stat(input int i, input logic [1:0] st, input logic [3:0] rate,
                        input logic c56);
        check({9'h0, input_status[i]}, {9'h0, st, rate, c56}, "input status");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0; force_internal = 1'b0; preferred_source = SRC_INTERNAL;
        host_rate = 4'h0; internal_rate = 4'h7; record_request = '0;
        want = '0; obs = '0; n_errors = 0; checks_done = 0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (10) @(posedge clock);
        core(SRC_INTERNAL, RATE_NONE);
        for (int i = 0; i < NUM_INPUTS; i++) stat(i, STATE_NO_LOCK, RATE_NONE, 1'b0);
        $display("Test reset state done");

        obs[IDX_WORD] = '{1'b1, 1'b0, 1'b0, 4'h3};
        drive(SRC_WORD, 1'b0, 4'h5, 5'b10001);
        settle();
        core(SRC_WORD, 4'h3);
        stat(IDX_WORD, STATE_LOCK, 4'h3, 1'b0);
        check({11'h0, record_enable}, 16'h0001, "record enable");
        obs[IDX_WORD].synced = 1'b1;
        drive(SRC_WORD, 1'b0, 4'h3, 5'b10001);
        settle();
        stat(IDX_WORD, STATE_SYNC, 4'h3, 1'b0);
        core(SRC_WORD, 4'h3);
        $display("Test word slave done");

        for (int s = 1; s <= NUM_INPUTS; s++) begin
            obs = '0;
            obs[s-1] = '{1'b1, 1'b1, 1'b1, 4'(s + 2)};
            drive(3'(s), 1'b0, 4'h3, 5'h1F);
            settle();
            core(3'(s), 4'(s + 2));
            stat(s - 1, STATE_SYNC, 4'(s + 2), (s >= 2) && (s <= 4));
            check({11'h0, record_enable}, 16'(1 << (s - 1)), "record enable");
        end
        $display("Test every source done");

        obs = '0;
        obs[IDX_MADI1] = '{1'b1, 1'b0, 1'b0, 4'h2};
        obs[IDX_AES]   = '{1'b1, 1'b0, 1'b0, 4'h6};
        drive(SRC_MADI1, 1'b0, 4'h3, 5'h00);
        settle();
        core(SRC_MADI1, 4'h2);
        obs[IDX_MADI1] = '0;
        drive(SRC_MADI1, 1'b0, 4'h3, 5'h00);
        settle();
        core(SRC_AES, 4'h6);
        obs[IDX_AES] = '0;
        drive(SRC_MADI1, 1'b0, 4'h3, 5'h00);
        settle();
        core(SRC_INTERNAL, RATE_NONE);
        $display("Test fallback done");

        obs[IDX_WORD] = '{1'b1, 1'b0, 1'b0, RATE_NONE};
        drive(SRC_WORD, 1'b0, 4'h3, 5'h01);
        settle();
        stat(IDX_WORD, STATE_NO_LOCK, RATE_NONE, 1'b0);
        core(SRC_INTERNAL, RATE_NONE);
        check({11'h0, record_enable}, 16'h0000, "record enable");
        $display("Test unknown rate done");

        obs[IDX_WORD] = '{1'b1, 1'b0, 1'b0, 4'h4};
        drive(SRC_WORD, 1'b1, 4'h3, 5'h00);
        settle();
        core(SRC_INTERNAL, RATE_NONE);
        stat(IDX_WORD, STATE_LOCK, 4'h4, 1'b0);
        drive(SRC_WORD, 1'b0, 4'h3, 5'h00);
        settle();
        core(SRC_WORD, 4'h4);
        drive(SRC_INTERNAL, 1'b0, 4'h3, 5'h00);
        settle();
        core(SRC_WORD, 4'h4);
        $display("Test forced internal done");

        // A drop shorter than one frame must not move the reference
        obs[IDX_WORD] = '0;
        drive(SRC_WORD, 1'b0, 4'h3, 5'h00);
        repeat (10) @(posedge clock);
        obs[IDX_WORD] = '{1'b1, 1'b0, 1'b0, 4'h4};
        drive(SRC_WORD, 1'b0, 4'h3, 5'h00);
        // An undebounced drop would reach the selection inside this window
        for (int c = 0; c < 40; c++) begin
            @(negedge clock);
            check({13'h0, current_source}, {13'h0, SRC_WORD}, "source across drop");
        end
        settle();
        core(SRC_WORD, 4'h4);
        $display("Test debounce done");
        finish_test();
    end

    // All tests take about 1900 cycles; this span leaves wide margin
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule // audio_clock_source_select_tb
`default_nettype wire
